/* File: tb/pop_pack_model.sv */
// Pack side model: charge gate resistor and load sense divider
`timescale 1ns/1ns
`default_nettype none
module pop_pack_model (
  input  wire logic drive_o,    // Charge drive level
  input  wire logic drive_oe_n, // Low while drive is on
  input  wire logic pull_en,    // Internal load resistor on
  input  wire logic load_on,    // Load still attached
  output logic      gate,       // Charge switch gate level
  output logic      load_cmp    // Load sense comparator
);
  // Released gate falls through the external resistor
  assign gate = drive_oe_n ? 1'b0 : drive_o;
  // Divider forms only with the internal resistor; open pin floats high
  assign load_cmp = pull_en ? load_on : 1'b1;
endmodule
`default_nettype wire

/* File: tb/pop_top_tb_top.sv */
// Self-checking bench for the pack protection core
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("FAIL t=%0t got %h exp %h", $time, (g), (e)); end end
module pop_top_tb_top
  import pop_pkg::*;
;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r;} pop_row_t;
  localparam int US = TICK_CYC; // Cycles per microsecond
  // Rows: address, written value, read-back value
  pop_row_t rows [7] = '{'{8'h05, 8'h39, 8'h39}, '{8'h06, 8'h24, 8'h24},
    '{8'h07, 8'h00, 8'h00}, '{8'h09, 8'h13, 8'h13}, '{8'h09, 8'h17, 8'h17},
    '{8'h08, 8'hff, 8'h00}, '{8'h0a, 8'h07, 8'h00}};
  logic       clk_sys = 1'b0, arst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0;
  logic       reg_rd = 1'b0, cell1_ok = 1'b1, cell2_ok = 1'b1;
  logic       cell3_ok = 1'b1, vcc_ok = 1'b0, wake_pin = 1'b1;
  logic       coc_cmp = 1'b0, doc_cmp = 1'b0, dsc_cmp = 1'b0, load_on = 1'b0;
  logic       load_sense_cmp, charge_gate, regulator_output;
  logic       discharge_switch_drive, charge_switch_drive_o;
  logic       charge_switch_drive_oe_n, thermistor_supply_out;
  logic       load_sense_pulldown;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_v;
  logic [1:0] doc_thr_sel, dsc_thr_sel, coc_thr_sel;
  int         bad_count = 0, n_compared = 0, cyc = 0;

  // Short delays keep discharge and short circuit trips within a few hundred cycles
  pop_top #(.DOC_BASE_US(64), .SC_DLY0_US(4), .SC_DLY1_US(8)) i_pop_top (
    .clk_sys, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cell1_ok, .cell2_ok, .cell3_ok, .vcc_ok, .wake_pin,
    .coc_cmp, .doc_cmp, .dsc_cmp, .load_sense_cmp, .doc_thr_sel,
    .dsc_thr_sel, .coc_thr_sel, .regulator_output, .discharge_switch_drive,
    .charge_switch_drive_o, .charge_switch_drive_oe_n,
    .thermistor_supply_out, .load_sense_pulldown);
  pop_pack_model i_pop_pack_model (.drive_o(charge_switch_drive_o),
    .drive_oe_n(charge_switch_drive_oe_n), .pull_en(load_sense_pulldown),
    .load_on(load_on), .gate(charge_gate), .load_cmp(load_sense_cmp));

  // Clock, 20 ns period
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  // Settled point just after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
  endtask

  // One fault: k selects short or discharge, us is the selected delay
  task automatic fault(input logic [7:0] ctrl, input logic [1:0] k,
                       input int us);
    logic dis;
    dis = ctrl[k[1] ? 6 : 5];
    wr(8'h09, ctrl);
    @(posedge clk_sys);
    {dsc_cmp, doc_cmp} <= k;
    tick((us - 2) * US);
    `CHK(discharge_switch_drive, 1'b1)
    tick(4 * US);
    `CHK(discharge_switch_drive, dis)
    `CHK(charge_gate, dis)
    `CHK(charge_switch_drive_oe_n, ~dis)
    `CHK(thermistor_supply_out, 1'b1)
    rd(8'h0a);
    `CHK(rd_v, {5'h00, k, 1'b0})
    rd(8'h09);
    `CHK(rd_v, ctrl & (dis ? 8'hff : 8'hfc))
    @(posedge clk_sys);
    {dsc_cmp, doc_cmp} <= 2'b00;
    tick(10);
    rd(8'h0a);
    `CHK(rd_v, {5'h00, k, 1'b0})
    wr(8'h0a, 8'h07);
    tick(2);
    `CHK(thermistor_supply_out, 1'b0)
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys);
    `CHK(regulator_output, 1'b0)
    arst_n <= 1'b1;
    tick(8);
    `CHK(regulator_output, 1'b0)
    @(posedge clk_sys);
    vcc_ok <= 1'b1;
    tick(5);
    `CHK(regulator_output, 1'b1)
    `CHK(charge_switch_drive_oe_n, 1'b1)
    `CHK(load_sense_pulldown, 1'b0)
    `CHK(thermistor_supply_out, 1'b0)
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a);
      `CHK(rd_v, rows[i].r)
    end
    `CHK({doc_thr_sel, dsc_thr_sel, coc_thr_sel}, 6'b011010)
    `CHK(charge_gate, 1'b1)
    `CHK(load_sense_pulldown, 1'b1)
    // Load present, then released
    @(posedge clk_sys);
    load_on <= 1'b1;
    tick(6);
    rd(8'h0a);
    `CHK(rd_v, 8'h08)
    @(posedge clk_sys);
    load_on <= 1'b0;
    tick(6);
    rd(8'h0a);
    `CHK(rd_v, 8'h00)
    // Two short bursts must not add up to a trip
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_sys);
      doc_cmp <= 1'b1;
      repeat (6 * US) @(posedge clk_sys);
      doc_cmp <= 1'b0;
      repeat (2 * US) @(posedge clk_sys);
    end
    rd(8'h0a);
    `CHK(rd_v, 8'h00)
    fault(8'h17, 2'b01, 8);
    fault(8'h37, 2'b01, 8);
    fault(8'h17, 2'b10, 4);
    fault(8'h57, 2'b10, 4);
    // Sleep and wake for both polarities
    for (int p = 0; p < 2; p++) begin
      wr(8'h07, p[7:0]);
      wr(8'h09, 8'h08);
      tick(20);
      `CHK(regulator_output, 1'b0)
      @(posedge clk_sys);
      wake_pin <= p[0];
      for (int i = 0; i < 10 && regulator_output !== 1'b1; i++) tick(1);
      `CHK(regulator_output, 1'b1)
    end
    // Supply loss clears the registers and flags
    @(posedge clk_sys);
    cell2_ok <= 1'b0;
    tick(4);
    `CHK(regulator_output, 1'b0)
    @(posedge clk_sys);
    cell2_ok <= 1'b1;
    tick(5);
    `CHK(regulator_output, 1'b1)
    rd(8'h05);
    `CHK(rd_v, 8'h00)
    test_done();
  end
endmodule
`default_nettype wire

/* File: verilog/pop_pkg.sv */
// Constants for the pack overcurrent protection block
package pop_pkg;
  localparam int          CLK_HZ      = 50_000_000;
  localparam int          TICK_US     = 1;
  localparam int          TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam logic [7:0]  ADDR_DSET   = 8'h05;
  localparam logic [7:0]  ADDR_CSET   = 8'h06;
  localparam logic [7:0]  ADDR_FEAT   = 8'h07;
  localparam logic [7:0]  ADDR_CTRL   = 8'h09;
  localparam logic [7:0]  ADDR_STAT   = 8'h0a;
  localparam logic [7:0]  REG_RST     = 8'h00;
  // Control register fields
  localparam int          CT_CHG      = 0;
  localparam int          CT_DIS      = 1;
  localparam int          CT_LDMON    = 2;
  localparam int          CT_SLEEP    = 3;
  localparam int          CT_DIS0     = 4;
  // Status register fields, fault order coc, doc, dsc
  localparam int          ST_LOAD     = 3;
  // Discharge set fields
  localparam int          DS_DOCDLY   = 4;
  localparam int          DS_SCDLY    = 7;
  // Charge set fields, discharge delay shift and feature wake polarity bit
  localparam int          CS_DISCHARGE_DELAY_SCALE    = 2;
  localparam int          CS_CHARGE_DELAY_SCALE    = 3;
  localparam int          DISCHARGE_DELAY_SCALE_SHIFT = 6;
  localparam int          FEAT_WAKE_EDGE_POLARITY  = 0;
  // Charge timeout base figures in microseconds
  localparam int          OCC_BASE_US = 80_000;
  localparam int          OCC_FAST_US = 2_500;
  localparam int          NFLT        = 3;
  localparam int          DW          = 24;
  typedef enum logic [2:0] {
    PS_OFF   = 3'b001,
    PS_AWAKE = 3'b010,
    PS_SLEEP = 3'b100
  } pop_pwr_t;
endpackage

/* File: verilog/pop_top.sv */
// Pack protection core: power state, fault timing, drives, registers
//
// The implementer's own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pop_top
  import pop_pkg::*;
#(
  parameter int DOC_BASE_US = 10_000, // Discharge delay step zero
  parameter int SC_DLY0_US  = 200,    // Short circuit delay zero
  parameter int SC_DLY1_US  = 400     // Short circuit delay one
) (
  input  wire logic       clk_sys,             // System clock
  input  wire logic       arst_n,              // Async reset
  input  wire logic       clk_en,              // Freezes state low
  input  wire logic [7:0] reg_addr,            // Register address
  input  wire logic [7:0] reg_wdata,           // Write data
  input  wire logic       reg_wr,              // Write strobe
  input  wire logic       reg_rd,              // Read strobe
  output logic      [7:0] reg_rdata,           // Read data
  input  wire logic       cell1_ok,            // Cell 1 above POR
  input  wire logic       cell2_ok,            // Cell 2 above POR
  input  wire logic       cell3_ok,            // Cell 3 above POR
  input  wire logic       vcc_ok,              // Main supply above POR
  input  wire logic       wake_pin,            // Wake pin level
  input  wire logic       coc_cmp,             // Charge OC comparator
  input  wire logic       doc_cmp,             // Discharge OC comp
  input  wire logic       dsc_cmp,             // Short circuit comp
  input  wire logic       load_sense_cmp,      // Load still present
  output logic      [1:0] doc_thr_sel,         // Discharge OC level
  output logic      [1:0] dsc_thr_sel,         // Short circuit level
  output logic      [1:0] coc_thr_sel,         // Charge OC level
  output logic            regulator_output,    // Regulator enable
  output logic            discharge_switch_drive, // Driven gate
  output logic            charge_switch_drive_o,  // Charge gate out
  output logic            charge_switch_drive_oe_n, // Low drives
  output logic            thermistor_supply_out,  // Fault flag interrupt
  output logic            load_sense_pulldown     // Pulls pin low
);
  // Synchroniser chains for pins
  localparam int NS = 8;
  logic [NS-1:0] pin_raw;
  logic [NS-1:0] sy1_q, sy1_d, sy2_q, sy2_d;
  logic          sup_ok, wake_s, load_s;
  logic [NFLT-1:0] cmp_s;
  logic          cell1_a_q, cell1_s;
  assign pin_raw = {load_sense_cmp, dsc_cmp, doc_cmp, coc_cmp,
                    wake_pin, vcc_ok, cell3_ok, cell2_ok};
  assign sup_ok = sy2_q[0] & sy2_q[1] & sy2_q[2] & cell1_s;

  // Two flip-flop capture of pins
  always_comb begin
    sy1_d = pin_raw;
    sy2_d = sy1_q;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sy1_q     <= '0;
      sy2_q     <= '0;
      cell1_a_q <= 1'b0;
      cell1_s   <= 1'b0;
    end else if (clk_en) begin
      sy1_q     <= sy1_d;
      sy2_q     <= sy2_d;
      cell1_a_q <= cell1_ok;
      cell1_s   <= cell1_a_q;
    end
  end
  assign wake_s = sy2_q[3];
  assign cmp_s  = sy2_q[6:4] & 3'b111;
  assign load_s = sy2_q[7];

  // Microsecond tick prescaler
  logic [7:0] pre_q, pre_d;
  logic       tick;
  assign tick = (pre_q == 8'(TICK_CYC - 1));
  always_comb begin
    pre_d = tick ? 8'h00 : pre_q + 8'h01;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pre_q <= 8'h00;
    else if (clk_en) pre_q <= pre_d;
  end

  // Registers and power state
  pop_pwr_t    pwr_q, pwr_d;
  logic [7:0]  dset_q, dset_d, cset_q, cset_d;
  logic [7:0]  feat_q, feat_d, ctrl_q, ctrl_d;
  logic [2:0]  flag_q, flag_d;
  logic [7:0]  rdata_d;
  logic        load_present_q, load_present_d;
  logic [NFLT-1:0] evt, trip;
  logic        any_trip, awake, wk_hit;
  logic        wr_dset, wr_cset, wr_feat, wr_ctrl, wr_stat;
  assign awake    = (pwr_q == PS_AWAKE);
  assign trip     = evt & ~ctrl_q[CT_DIS0 +: NFLT];
  assign any_trip = |trip;
  assign wk_hit   = feat_q[FEAT_WAKE_EDGE_POLARITY] ? wake_s : ~wake_s;
  assign wr_dset  = reg_wr && reg_addr == ADDR_DSET;
  assign wr_cset  = reg_wr && reg_addr == ADDR_CSET;
  assign wr_feat  = reg_wr && reg_addr == ADDR_FEAT;
  assign wr_ctrl  = reg_wr && reg_addr == ADDR_CTRL;
  assign wr_stat  = reg_wr && reg_addr == ADDR_STAT;

  // Next state for registers, flags and power
  always_comb begin
    pwr_d  = pwr_q;
    dset_d = wr_dset ? reg_wdata : dset_q;
    cset_d = wr_cset ? reg_wdata : cset_q;
    feat_d = wr_feat ? reg_wdata : feat_q;
    ctrl_d = wr_ctrl ? reg_wdata : ctrl_q;
    ctrl_d[CT_SLEEP] = 1'b0;
    flag_d = flag_q;
    if (wr_stat) flag_d = flag_q & ~reg_wdata[2:0];
    flag_d = flag_d | evt;
    if (any_trip) begin
      ctrl_d[CT_CHG] = 1'b0;
      ctrl_d[CT_DIS] = 1'b0;
    end
    unique case (pwr_q)
      PS_OFF: begin
        if (sup_ok) pwr_d = PS_AWAKE;
      end
      PS_AWAKE: begin
        if (!sup_ok) pwr_d = PS_OFF;
        else if (wr_ctrl && reg_wdata[CT_SLEEP]) pwr_d = PS_SLEEP;
      end
      PS_SLEEP: begin
        if (!sup_ok) pwr_d = PS_OFF;
        else if (wk_hit) pwr_d = PS_AWAKE;
      end
      default: pwr_d = PS_OFF;
    endcase
    if (pwr_q == PS_OFF) begin
      dset_d = REG_RST;
      cset_d = REG_RST;
      feat_d = REG_RST;
      ctrl_d = REG_RST;
      flag_d = 3'b000;
    end
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_DSET: rdata_d = dset_q;
        ADDR_CSET: rdata_d = cset_q;
        ADDR_FEAT: rdata_d = feat_q;
        ADDR_CTRL: rdata_d = ctrl_q;
        ADDR_STAT: rdata_d = {4'h0, load_present_q, flag_q};
        default:   rdata_d = 8'h00;
      endcase
    end
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pwr_q     <= PS_OFF;
      dset_q    <= REG_RST;
      cset_q    <= REG_RST;
      feat_q    <= REG_RST;
      ctrl_q    <= REG_RST;
      flag_q    <= 3'b000;
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      pwr_q     <= pwr_d;
      dset_q    <= dset_d;
      cset_q    <= cset_d;
      feat_q    <= feat_d;
      ctrl_q    <= ctrl_d;
      flag_q    <= flag_d;
      reg_rdata <= rdata_d;
    end
  end

  // Delay selection in microseconds
  logic [DW-1:0] dly [NFLT];
  logic [DW-1:0] doc_full, occ_base;
  always_comb begin
    occ_base = cset_q[CS_CHARGE_DELAY_SCALE] ? DW'(OCC_FAST_US) : DW'(OCC_BASE_US);
    dly[0]   = occ_base << cset_q[1:0];
    doc_full = DW'(DOC_BASE_US) << dset_q[DS_DOCDLY +: 3];
    dly[1]   = cset_q[CS_DISCHARGE_DELAY_SCALE] ? doc_full >> DISCHARGE_DELAY_SCALE_SHIFT
                                : doc_full;
    dly[2]   = dset_q[DS_SCDLY] ? DW'(SC_DLY1_US)
                                : DW'(SC_DLY0_US);
  end

  // Per fault delay counters
  genvar gi;
  generate
    for (gi = 0; gi < NFLT; gi++) begin : g_flt
      logic [DW-1:0] cnt_q, cnt_d;
      logic          hit_q, hit_d;
      logic          ev_g;
      assign evt[gi] = ev_g;
      always_comb begin
        cnt_d   = cnt_q;
        hit_d   = hit_q;
        ev_g    = 1'b0;
        if (!cmp_s[gi] || !awake) begin
          cnt_d = '0;
          hit_d = 1'b0;
        end else if (tick && !hit_q) begin
          if (cnt_q >= dly[gi]) begin
            hit_d   = 1'b1;
            ev_g    = 1'b1;
          end else begin
            cnt_d = cnt_q + DW'(1);
          end
        end
      end
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          cnt_q <= '0;
          hit_q <= 1'b0;
        end else if (clk_en) begin
          cnt_q <= cnt_d;
          hit_q <= hit_d;
        end
      end
    end
  endgenerate

  // Load monitor flag
  always_comb begin
    load_present_d = ctrl_q[CT_LDMON] & load_s;
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) load_present_q <= 1'b0;
    else if (clk_en) load_present_q <= load_present_d;
  end

  // Pin drives follow control bits, power state and fault flags
  assign doc_thr_sel = dset_q[1:0];
  assign dsc_thr_sel = dset_q[3:2];
  assign coc_thr_sel = cset_q[5:4];
  assign regulator_output = (pwr_q != PS_OFF) && (pwr_q != PS_SLEEP);
  assign discharge_switch_drive = awake & ctrl_q[CT_DIS];
  assign charge_switch_drive_o  = 1'b1;
  assign charge_switch_drive_oe_n =
    ~(awake & ctrl_q[CT_CHG]);
  assign thermistor_supply_out = |flag_q;
  assign load_sense_pulldown = ctrl_q[CT_LDMON];

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_doc_evt;
    clk_en && evt[1];
  endsequence
  sequence s_off_both;
    !discharge_switch_drive && charge_switch_drive_oe_n;
  endsequence
  a_doc_trip_off: assert property (s_doc_evt and !ctrl_q[CT_DIS0+1]
    |=> s_off_both)
    else $error("doc trip left a drive on");
  a_dsc_trip_off: assert property (clk_en && evt[2]
    && !ctrl_q[CT_DIS0+2] |=> !ctrl_q[CT_CHG] && !ctrl_q[CT_DIS])
    else $error("short trip kept control bits");
  a_coc_trip_flag: assert property (clk_en && evt[0]
    |=> flag_q[0])
    else $error("coc flag not set");
  a_doc_dis_hold: assert property (s_doc_evt and (ctrl_q[CT_DIS0+1]
    && !evt[0] && !evt[2] && !wr_ctrl && awake && sup_ok)
    |=> ctrl_q[CT_DIS] == $past(ctrl_q[CT_DIS]))
    else $error("disabled doc moved drive");
  a_dsc_dis_flag: assert property (clk_en && evt[2]
    && ctrl_q[CT_DIS0+2] |=> flag_q[2])
    else $error("disabled short lost flag");
  a_coc_dis_hold: assert property (clk_en && evt[0]
    && ctrl_q[CT_DIS0] && !evt[1] && !evt[2] && !wr_ctrl
    && awake && sup_ok |=> ctrl_q[CT_CHG] == $past(ctrl_q[CT_CHG]))
    else $error("disabled coc moved drive");
  a_flag_irq_out: assert property (|flag_q
    |-> thermistor_supply_out)
    else $error("interrupt low with flag set");
  a_flag_sticky: assert property (clk_en && flag_q[1] && awake
    && !wr_stat && $stable(pwr_q) |=> flag_q[1])
    else $error("flag dropped without clear");
  a_cnt_restart: assert property (clk_en && !cmp_s[1]
    |=> g_flt[1].cnt_q == '0)
    else $error("counter not restarted");
  a_wake_low: assert property (clk_en && pwr_q == PS_SLEEP
    && sup_ok && !feat_q[FEAT_WAKE_EDGE_POLARITY] && !wake_s
    |=> pwr_q == PS_AWAKE)
    else $error("no wake on low pin");
  a_power_loss: assert property (clk_en && pwr_q != PS_OFF
    && !sup_ok |=> pwr_q == PS_OFF ##0 !regulator_output)
    else $error("supply loss ignored");
  a_load_flag: assert property (clk_en && !ctrl_q[CT_LDMON]
    |=> !load_present_q)
    else $error("load flag without monitor");

  // Power state and regulator checks
  sequence s_supply_good;
    clk_en && sup_ok;
  endsequence
  sequence s_sleep_cmd;
    wr_ctrl && reg_wdata[CT_SLEEP];
  endsequence
  a_power_up_wake: assert property (
    s_supply_good and (pwr_q == PS_OFF)
    |=> pwr_q == PS_AWAKE)
    else $error("no wake with supplies good");
  a_regulator_state: assert property (
    regulator_output == awake)
    else $error("regulator not tied to awake");
  a_stay_awake: assert property (
    s_supply_good and (awake && !wr_ctrl)
    |=> awake)
    else $error("left awake state unasked");
  a_sleep_entry: assert property (
    s_supply_good and s_sleep_cmd and awake
    |=> pwr_q == PS_SLEEP)
    else $error("sleep command ignored");
  a_wake_high: assert property (
    clk_en && pwr_q == PS_SLEEP && sup_ok
    && feat_q[FEAT_WAKE_EDGE_POLARITY] && wake_s
    |=> pwr_q == PS_AWAKE)
    else $error("no wake on high pin");
  a_sleep_hold: assert property (
    clk_en && pwr_q == PS_SLEEP && sup_ok && !wk_hit
    |=> pwr_q == PS_SLEEP)
    else $error("woke without wake level");

  // Fault timing, flags and drive checks
  a_trip_needs_cmp: assert property (
    |evt |-> awake && (evt & ~cmp_s) == '0)
    else $error("event without comparator");
  a_doc_set_flag: assert property (
    clk_en && evt[1] |=> flag_q[1])
    else $error("doc flag not set");
  a_dsc_set_flag: assert property (
    clk_en && evt[2] |=> flag_q[2])
    else $error("short flag not set");
  a_coc_trip_off: assert property (
    clk_en && evt[0] && !ctrl_q[CT_DIS0]
    |=> s_off_both)
    else $error("coc trip left a drive on");
  a_coc_dis_flag: assert property (
    clk_en && evt[0] && ctrl_q[CT_DIS0] |=> flag_q[0])
    else $error("disabled coc lost flag");
  a_evt_sets_flag: assert property (
    clk_en && |evt |=> (flag_q & $past(evt)) == $past(evt))
    else $error("event lost its flag");
  a_trip_clear_bits: assert property (
    clk_en && any_trip |=> ctrl_q[CT_CHG +: 2] == 2'b00)
    else $error("trip kept switch bits");
  a_auto_disable: assert property (
    clk_en && |evt && !any_trip && !wr_ctrl && awake && sup_ok
    |=> ctrl_q[CT_CHG +: 2] == $past(ctrl_q[CT_CHG +: 2]))
    else $error("disabled fault moved switch bits");
  a_host_enable: assert property (
    clk_en && wr_ctrl && !any_trip && awake && sup_ok
    |=> ctrl_q[CT_CHG +: 2] == $past(reg_wdata[CT_CHG +: 2]))
    else $error("host enable refused");
  a_dis_drive_off: assert property (
    !ctrl_q[CT_DIS] |-> !discharge_switch_drive)
    else $error("discharge drive on without bit");
  a_chg_released: assert property (
    !ctrl_q[CT_CHG] |-> charge_switch_drive_oe_n
    && charge_switch_drive_o)
    else $error("charge drive not released");

  // Load monitor and delay selection checks
  a_ldmon_pull: assert property (
    load_sense_pulldown == ctrl_q[CT_LDMON])
    else $error("pull-down not following monitor");
  a_load_seen: assert property (
    clk_en && ctrl_q[CT_LDMON] && load_s |=> load_present_q)
    else $error("load flag missed");
  a_occ_longest: assert property (
    !cset_q[CS_CHARGE_DELAY_SCALE] && cset_q[1:0] == 2'b11
    |-> dly[0] == DW'(OCC_BASE_US << 3))
    else $error("charge delay not longest step");
  a_occ_fast: assert property (
    cset_q[CS_CHARGE_DELAY_SCALE] && cset_q[1:0] == 2'b00
    |-> dly[0] == DW'(OCC_FAST_US))
    else $error("fast charge delay wrong");
  a_doc_divided: assert property (
    cset_q[CS_DISCHARGE_DELAY_SCALE] && dset_q[DS_DOCDLY +: 3] == 3'h0
    |-> dly[1] == DW'(DOC_BASE_US >> DISCHARGE_DELAY_SCALE_SHIFT))
    else $error("discharge delay not divided");
endmodule
`default_nettype wire

/* File: verilog/unused_placeholder_none.sv */
// Intentionally empty design unit list
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire
